/* hw/vsf_sequencer.v */
// VID code mux, slew stepper, power-good blanking, fault latch and mode decode.
// Assumes pins are asynchronous; analog comparators arrive as levels; Wishbone master on clk.
// Notes on behaviour
// - Both selects low: code from logic levels; impedance select high: from sensed impedances.
// - Suspend select high: code from two suspend code inputs, impedance select ignored.
// - Power-good blanked from transition start, cannot go low during transition.
// - Power-good re-enabled after final code reached plus one slew period.
// - One 25mV code step per slew period; start delay before, one period after.
// - Start delay is zero to one slew period.
// - Slew period programmable over 2.6us to 26us per step.
// - Output above 2V trips overvoltage, shuts down, drives low-side gate high.
// - Overvoltage keeps low-side gate latched high until skip pin toggled or reset.
// - Low-side gate high during supply lockout (reset) and shutdown.
// - Overvoltage disabled by disable input high or fault-disable test mode.
// - Undervoltage below 70% latches PWM off until reset or skip pin toggled.
// - Undervoltage ignored for the first 256 slew periods after startup.
// - Skip pin grounded: shutdown, low-side gate forced high.
// - Skip pin open: forced fixed-frequency PWM, no automatic switchover.
// - Skip pin at supply: automatic PWM/PFM switchover.
// - Overvoltage, undervoltage or thermal set one fault latch holding gate high.
// - Skip pin at test level: faults disabled and fault latch cleared.
// - Test mode regulates like skip mode with pin high.
// - Impedances sampled on impedance select rise, power-up with it high, suspend fall.
// - Sampling applies opposing pull about 4us; level change means impedance state 1.
`timescale 1ns/1ps
`include "vsf_regs.vh"
module vsf_sequencer #(
   parameter CODE_W = 5
) (
   input  wire              clk,
   input  wire              reset_n,
   input  wire [31:0]       wb_adr_i,
   input  wire [31:0]       wb_dat_i,
   input  wire [3:0]        wb_sel_i,
   input  wire              wb_we_i,
   input  wire              wb_cyc_i,
   input  wire              wb_stb_i,
   output reg  [31:0]       wb_dat_o,
   output reg               wb_ack_o,
   input  wire              impedance_mode_select,
   input  wire              suspend_select,
   input  wire [CODE_W-1:0] vid_code_inputs,
   input  wire [1:0]        suspend_code_inputs,
   input  wire [1:0]        skip_shutdown_control,
   input  wire              overvoltage_disable_input,
   input  wire              overvoltage_detect,
   input  wire              undervoltage_detect,
   input  wire              thermal_detect,
   output reg  [CODE_W-1:0] vid_pull_enable,
   output reg  [CODE_W-1:0] vid_pull_up,
   output reg  [CODE_W-1:0] dac_code,
   output reg               power_good_output,
   output reg               low_side_gate_drive,
   output reg               pwm_enable,
   output reg               skip_enable
);
   localparam ST_IDLE  = 4'b0001;
   localparam ST_DELAY = 4'b0010;
   localparam ST_STEP  = 4'b0100;
   localparam ST_TAIL  = 4'b1000;
   localparam Z_IDLE   = 3'b001;
   localparam Z_SETTLE = 3'b010;
   localparam Z_PULL   = 3'b100;

   wire                s_impedance_mode_select;
   wire                s_sus;
   wire [CODE_W-1:0]   s_vid;
   wire [1:0]          s_scode;
   wire [1:0]          s_skp;
   wire                s_ovdis;
   wire                s_ov;
   wire                s_uv;
   wire                s_th;
   vsf_sync2 #(.WIDTH(CODE_W + 10)) u_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .d       ({impedance_mode_select, suspend_select, vid_code_inputs, suspend_code_inputs,
                 skip_shutdown_control, overvoltage_disable_input, overvoltage_detect,
                 undervoltage_detect, thermal_detect}),
      .q       ({s_impedance_mode_select, s_sus, s_vid, s_scode, s_skp, s_ovdis, s_ov, s_uv, s_th})
   );

   reg [31:0]          ctrl;
   reg [15:0]          slew_div;
   reg [8:0]           uv_blank;
   reg [15:0]          div_cnt;
   reg                 tick;
   reg [1:0]           ph_cnt;
   reg                 impedance_mode_select_d;
   reg                 sus_d;
   reg                 started;
   reg [2:0]           z_state;
   reg [9:0]           z_cnt;
   reg [CODE_W-1:0]    z_code;
   reg [CODE_W-1:0]    z_base;
   reg [3:0]           state;
   reg [CODE_W-1:0]    target;
   reg                 fault;
   reg [1:0]           skp_d;
   reg [8:0]           uv_cnt;
   reg [CODE_W-1:0]    sel_code;

   // Slew period divider; no clock enable, tick is a one-cycle strobe
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         div_cnt <= 16'h0000;
         tick    <= 1'b0;
      end
      else if (div_cnt >= slew_div - 16'h0001)
      begin
         div_cnt <= 16'h0000;
         tick    <= 1'b1;
      end
      else
      begin
         div_cnt <= div_cnt + 16'h0001;
         tick    <= 1'b0;
      end
   end

   // Suspend codes map onto the upper code range, 0.975V downward
   always @*
   begin
      if (s_sus)
         sel_code = {1'b1, 2'b00, s_scode};
      else if (s_impedance_mode_select)
         sel_code = z_code;
      else
         sel_code = s_vid;
   end

   // Impedance sampler
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         z_state         <= Z_IDLE;
         z_cnt           <= 10'h000;
         z_code          <= {CODE_W{1'b0}};
         z_base          <= {CODE_W{1'b0}};
         vid_pull_enable <= {CODE_W{1'b0}};
         vid_pull_up     <= {CODE_W{1'b0}};
         impedance_mode_select_d         <= 1'b0;
         sus_d           <= 1'b0;
         started         <= 1'b0;
      end
      else
      begin
         impedance_mode_select_d <= s_impedance_mode_select;
         sus_d   <= s_sus;
         started <= 1'b1;
         case (z_state)
            Z_IDLE:
            begin
               if ((s_impedance_mode_select && !impedance_mode_select_d) || (s_impedance_mode_select && !started) || (s_impedance_mode_select && sus_d && !s_sus))
               begin
                  z_state <= Z_SETTLE;
                  z_cnt   <= 10'h000;
               end
            end
            Z_SETTLE:
            begin
               // Record levels, then pull each pin the other way
               z_base          <= s_vid;
               vid_pull_up     <= ~s_vid;
               vid_pull_enable <= {CODE_W{1'b1}};
               z_state         <= Z_PULL;
            end
            Z_PULL:
            begin
               z_cnt <= z_cnt + 10'h001;
               if (z_cnt == `VSF_ZSAMPLE_CYC - 1)
               begin
                  z_code          <= s_vid ^ z_base;
                  vid_pull_enable <= {CODE_W{1'b0}};
                  z_state         <= Z_IDLE;
               end
            end
            default:
               z_state <= Z_IDLE;
         endcase
      end
   end

   // Slew stepper and power-good blanking
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state             <= ST_IDLE;
         target            <= {CODE_W{1'b1}};
         dac_code          <= {CODE_W{1'b1}};
         ph_cnt            <= 2'h0;
         power_good_output <= 1'b0;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               power_good_output <= ~fault && pwm_enable;
               if (sel_code != dac_code)
               begin
                  target            <= sel_code;
                  // Blanked: frozen at its level, so a window dip cannot pull it low
                  power_good_output <= power_good_output;
                  ph_cnt            <= 2'h0;
                  state             <= ST_DELAY;
               end
            end
            ST_DELAY:
            begin
               target <= sel_code;
               // First tick ends the delay, so it spans at most one period
               if (tick)
               begin
                  ph_cnt <= ph_cnt + 2'h1;
                  state  <= ST_STEP;
               end
            end
            ST_STEP:
            begin
               target <= sel_code;
               if (dac_code == target)
                  state <= ST_TAIL;
               else if (tick)
               begin
                  // Higher code is lower voltage; one code is one 25mV step
                  if (target > dac_code)
                     dac_code <= dac_code + 1'b1;
                  else
                     dac_code <= dac_code - 1'b1;
               end
            end
            ST_TAIL:
            begin
               if (sel_code != dac_code)
               begin
                  target <= sel_code;
                  state  <= ST_STEP;
               end
               else if (tick)
               begin
                  state             <= ST_IDLE;
                  power_good_output <= ~fault && pwm_enable;
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // Mode decode, fault latch and gate control
   wire test_mode = (s_skp == `VSF_SKP_TEST);
   wire shdn      = (s_skp == `VSF_SKP_GND);
   wire toggled   = shdn && (skp_d != `VSF_SKP_GND);
   wire ov_trip   = s_ov && !s_ovdis && !ctrl[`VSF_CTRL_OV_DIS] && !test_mode;
   wire uv_trip   = s_uv && (uv_cnt == uv_blank) && !test_mode;
   wire th_trip   = (s_th || ctrl[`VSF_CTRL_THERM]) && !test_mode;

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         fault               <= 1'b0;
         skp_d               <= `VSF_SKP_GND;
         uv_cnt              <= 9'h000;
         low_side_gate_drive <= 1'b1;
         pwm_enable          <= 1'b0;
         skip_enable         <= 1'b0;
      end
      else
      begin
         skp_d <= s_skp;
         if (ov_trip || uv_trip || th_trip)
            fault <= 1'b1;
         else if (test_mode || shdn)
            fault <= 1'b0;
         if (shdn)
            uv_cnt <= 9'h000;
         else if (tick && uv_cnt != uv_blank)
            uv_cnt <= uv_cnt + 9'h001;
         low_side_gate_drive <= shdn || fault || ov_trip || uv_trip || th_trip || toggled;
         pwm_enable          <= !shdn && !fault && !ov_trip && !uv_trip && !th_trip;
         skip_enable         <= (s_skp == `VSF_SKP_VCC) || test_mode;
      end
   end

   // Wishbone classic slave, one wait state, ack dropped after one cycle
   wire [7:0] wb_off = {wb_adr_i[7:2], 2'b00};
   wire       wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         ctrl     <= `VSF_CTRL_RESET;
         slew_div <= `VSF_DIV_RESET;
         uv_blank <= `VSF_UV_BLANK_CYC;
      end
      else
      begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h00000000;
         if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o)
         begin
            if (wb_off == `VSF_ADDR_CTRL && wb_sel_i[0])
               ctrl[1:0] <= wb_dat_i[1:0];
            if (wb_off == `VSF_ADDR_SLEW_DIV && wb_sel_i[1:0] == 2'h3)
            begin
               if (wb_dat_i[15:0] < `VSF_DIV_MIN)
                  slew_div <= `VSF_DIV_MIN;
               else if (wb_dat_i[15:0] > `VSF_DIV_MAX)
                  slew_div <= `VSF_DIV_MAX;
               else
                  slew_div <= wb_dat_i[15:0];
            end
         end
         else if (wb_req && !wb_we_i)
         begin
            case (wb_off)
               `VSF_ADDR_CTRL:
                  wb_dat_o <= {28'h0000000, s_uv, s_ov, ctrl[1:0]};
               `VSF_ADDR_STATUS:
                  wb_dat_o <= {24'h000000, pwm_enable, shdn, test_mode, skip_enable,
                               low_side_gate_drive, state != ST_IDLE, power_good_output, fault};
               `VSF_ADDR_SLEW_DIV:
                  wb_dat_o <= {16'h0000, slew_div};
               `VSF_ADDR_CODE:
                  wb_dat_o <= {11'h000, z_code, 3'h0, target, 3'h0, dac_code};
               `VSF_ADDR_UV_BLANK:
                  wb_dat_o <= {23'h000000, uv_cnt};
               default:
                  wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // vsf_sequencer

/* hw/vsf_sync2.v */
// Two-flip-flop synchroniser, one per bit, for pin inputs.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
module vsf_sync2 #(
   parameter WIDTH = 1
) (
   input  wire             clk,
   input  wire             reset_n,
   input  wire [WIDTH-1:0] d,
   output reg  [WIDTH-1:0] q
);
   reg [WIDTH-1:0] meta;
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta <= {WIDTH{1'b0}};
         q    <= {WIDTH{1'b0}};
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule // vsf_sync2

/* shared/vsf_regs.vh */
// Register map, field positions, reset values and timing counts of the VID slew and fault sequencer.
// Assumes a 100 MHz bus clock and 32-bit classic Wishbone with word addresses in adr[7:2].
`ifndef VSF_REGS_VH
`define VSF_REGS_VH
`define VSF_ADDR_CTRL       8'h00
`define VSF_ADDR_STATUS     8'h04
`define VSF_ADDR_SLEW_DIV   8'h08
`define VSF_ADDR_CODE       8'h0c
`define VSF_ADDR_UV_BLANK   8'h10
// CTRL fields
`define VSF_CTRL_OV_DIS     0
`define VSF_CTRL_THERM      1
`define VSF_CTRL_OV_DET     2
`define VSF_CTRL_UV_DET     3
`define VSF_CTRL_RESET      32'h00000000
// STATUS fields
`define VSF_ST_FAULT        0
`define VSF_ST_PGOOD        1
`define VSF_ST_BUSY         2
`define VSF_ST_DL           3
`define VSF_ST_SKIP         4
`define VSF_ST_TEST         5
`define VSF_ST_SHDN         6
`define VSF_ST_PWM_ON       7
// Skip/shutdown decode
`define VSF_SKP_GND         2'h0
`define VSF_SKP_OPEN        2'h1
`define VSF_SKP_VCC         2'h2
`define VSF_SKP_TEST        2'h3
// Timing
`define VSF_STEP_MV         25
`define VSF_STEP_MIN_NS     2600
`define VSF_STEP_MAX_NS     26000
`define VSF_CLK_NS          10
`define VSF_DIV_MIN         16'h0104
`define VSF_DIV_MAX         16'h0a28
`define VSF_DIV_RESET       16'h0104
`define VSF_UV_BLANK_CYC    9'h100
`define VSF_ZSAMPLE_NS      4000
`define VSF_ZSAMPLE_CYC     (`VSF_ZSAMPLE_NS / `VSF_CLK_NS)
`define VSF_ZSETTLE_CYC     2
`endif

/* verif/tb.sv */
// Self-checking bench: pins through the CPU model, registers over classic Wishbone.
// Assumes the slew divider at its reset value of 260 cycles per step.
`timescale 1ns/1ps
`include "vsf_regs.vh"
module tb;
   localparam int DIV = 260;
   logic        clk, reset_n, wb_we_i, wb_cyc_i, wb_stb_i, zm, su, pg_exp;
   logic        overvoltage_disable_input, overvoltage_detect, undervoltage_detect, thermal_detect;
   logic [31:0] wb_adr_i, wb_dat_i, rd;
   logic [3:0]  wb_sel_i;
   logic [4:0]  code, hiz, exp_dac, t;
   logic [1:0]  sc, sk;
   wire  [31:0] wb_dat_o;
   wire         wb_ack_o, impedance_mode_select, suspend_select, power_good_output;
   wire         low_side_gate_drive, pwm_enable, skip_enable;
   wire  [4:0]  vid_code_inputs, vid_pull_enable, vid_pull_up, dac_code;
   wire  [1:0]  suspend_code_inputs, skip_shutdown_control;
   int          checks = 0, err_total = 0, cycles = 0;
   integer      seed = 32'ha619850e;
   vsf_sequencer #(.CODE_W(5)) u_vsf_sequencer (.clk, .reset_n, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
      .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .impedance_mode_select, .suspend_select, .vid_code_inputs,
      .suspend_code_inputs, .skip_shutdown_control, .overvoltage_disable_input, .overvoltage_detect,
      .undervoltage_detect, .thermal_detect, .vid_pull_enable, .vid_pull_up, .dac_code, .power_good_output,
      .low_side_gate_drive, .pwm_enable, .skip_enable);
   vsf_cpu_model #(.CODE_W(5)) u_vsf_cpu_model (.clk, .want_impedance_mode_select(zm), .want_sus(su), .want_code(code),
      .want_hiz(hiz), .want_scode(sc), .want_skip(sk), .vid_pull_enable, .vid_pull_up, .impedance_mode_select,
      .suspend_select, .vid_code_inputs, .suspend_code_inputs, .skip_shutdown_control);
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Request held up to the edge that samples ack; data taken and request released there
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk);
      wb_adr_i <= {24'h0, a};
      wb_we_i  <= w;
      wb_dat_i <= d;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      chk("ack", {31'h0, wb_ack_o}, 32'h1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   function automatic logic [4:0] fresh();
      logic [4:0] r;
      r = 5'($random(seed));
      return (r == exp_dac) ? ~r : r;
   endfunction
   task automatic trans(input logic [4:0] tgt, input string what, input int lead);
      int n, steps;
      logic bad;
      steps = (tgt > exp_dac) ? tgt - exp_dac : exp_dac - tgt;
      n = 0;
      bad = 1'b0;
      // Power good must hold its level until the final code is reached
      while ((dac_code !== tgt || n < lead) && n < 12000)
      begin
         @(negedge clk);
         n++;
         bad = bad | (power_good_output !== pg_exp);
      end
      chk({what, " blank"}, {31'h0, bad}, 32'h0);
      chk({what, " time"}, {31'h0, n >= steps * DIV && n <= lead + (steps + 2) * DIV + 12}, 32'h1);
      chk(what, {27'h0, dac_code}, {27'h0, tgt});
      wb(`VSF_ADDR_STATUS, 1'b0, 32'h0);
      // An early arrival inside the lead may already have used up its tail period
      if (n > lead)
         chk({what, " tail"}, {31'h0, rd[`VSF_ST_BUSY]}, 32'h1);
      repeat (DIV) @(posedge clk);
      wb(`VSF_ADDR_CODE, 1'b0, 32'h0);
      chk({what, " code reg"}, {27'h0, rd[4:0]}, {27'h0, tgt});
      wb(`VSF_ADDR_STATUS, 1'b0, 32'h0);
      chk({what, " pgood"}, {30'h0, rd[`VSF_ST_BUSY], rd[`VSF_ST_PGOOD]}, 32'h1);
      exp_dac = tgt;
      pg_exp = 1'b1;
      $display("test %s done", what);
   endtask
   task automatic pin(input logic [1:0] s, input logic o, input logic th, input logic d, input logic e);
      @(posedge clk);
      sk <= s;
      overvoltage_detect <= o;
      thermal_detect <= th;
      overvoltage_disable_input <= d;
      repeat (8) @(negedge clk);
      chk("low side gate", {31'h0, low_side_gate_drive}, {31'h0, e});
   endtask
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 100000)
      begin
         err_total++;
         test_done();
      end
   end
   initial
   begin
      {wb_we_i, wb_cyc_i, wb_stb_i, zm, su, reset_n, pg_exp} = '0;
      {overvoltage_disable_input, overvoltage_detect, undervoltage_detect, thermal_detect} = '0;
      {wb_adr_i, wb_dat_i, hiz, sc} = '0;
      wb_sel_i = 4'hf;
      sk = 2'h2;
      exp_dac = 5'h1f;
      code = fresh();
      repeat (5) @(posedge clk);
      chk("dac reset", {27'h0, dac_code}, 32'h1f);
      chk("dl reset", {31'h0, low_side_gate_drive}, 32'h1);
      reset_n <= 1'b1;
      trans(code, "startup", 8);
      @(posedge clk);
      undervoltage_detect <= 1'b1;
      repeat (10) @(negedge clk);
      chk("uv blanked", {31'h0, pwm_enable}, 32'h1);
      @(posedge clk);
      undervoltage_detect <= 1'b0;
      wb(`VSF_ADDR_SLEW_DIV, 1'b0, 32'h0);
      chk("div reset", rd, {16'h0, `VSF_DIV_RESET});
      wb(`VSF_ADDR_SLEW_DIV, 1'b1, 32'hffff);
      wb(`VSF_ADDR_SLEW_DIV, 1'b0, 32'h0);
      chk("div max", rd, {16'h0, `VSF_DIV_MAX});
      wb(`VSF_ADDR_SLEW_DIV, 1'b1, 32'h0);
      wb(`VSF_ADDR_SLEW_DIV, 1'b0, 32'h0);
      chk("div min", rd, {16'h0, `VSF_DIV_MIN});
      wb(8'h40, 1'b0, 32'h0);
      chk("unmapped", rd, 32'h0);
      t = fresh();
      @(posedge clk);
      code <= t;
      trans(t, "logic", 8);
      t = fresh();
      @(posedge clk);
      hiz <= t;
      zm <= 1'b1;
      trans(t, "impedance_mode_select", 420);
      t = {3'b100, 2'($random(seed))};
      if (t == exp_dac)
         t[1:0] = ~t[1:0];
      @(posedge clk);
      sc <= t[1:0];
      su <= 1'b1;
      trans(t, "suspend", 8);
      t = fresh();
      @(posedge clk);
      hiz <= t;
      su <= 1'b0;
      trans(t, "resample", 420);
      t = fresh();
      @(posedge clk);
      code <= t;
      zm <= 1'b0;
      trans(t, "logic back", 8);
      while (cycles < 70500)
         @(posedge clk);
      @(posedge clk);
      undervoltage_detect <= 1'b1;
      repeat (8) @(negedge clk);
      chk("uv trip", {31'h0, pwm_enable}, 32'h0);
      @(posedge clk);
      undervoltage_detect <= 1'b0;
      repeat (8) @(negedge clk);
      chk("uv latched", {31'h0, pwm_enable}, 32'h0);
      pin(2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
      for (int i = 1; i < 4; i++)
      begin
         pin(2'(i), 1'b0, 1'b0, 1'b0, 1'b0);
         chk("skip mode", {31'h0, skip_enable}, {31'h0, i != 1});
         chk("pwm on", {31'h0, pwm_enable}, 32'h1);
      end
      pin(2'h2, 1'b1, 1'b0, 1'b1, 1'b0);
      pin(2'h3, 1'b1, 1'b0, 1'b0, 1'b0);
      pin(2'h2, 1'b1, 1'b0, 1'b0, 1'b1);
      pin(2'h2, 1'b0, 1'b0, 1'b0, 1'b1);
      pin(2'h0, 1'b0, 1'b0, 1'b0, 1'b1);
      pin(2'h2, 1'b0, 1'b1, 1'b0, 1'b1);
      pin(2'h2, 1'b0, 1'b0, 1'b0, 1'b1);
      pin(2'h3, 1'b0, 1'b0, 1'b0, 1'b0);
      pin(2'h2, 1'b0, 1'b0, 1'b0, 1'b0);
      wb(`VSF_ADDR_STATUS, 1'b0, 32'h0);
      chk("status run", rd, (32'h1 << `VSF_ST_PGOOD) | (32'h1 << `VSF_ST_SKIP) | (32'h1 << `VSF_ST_PWM_ON));
      wb(`VSF_ADDR_CTRL, 1'b1, 32'h1 << `VSF_CTRL_THERM);
      repeat (8) @(negedge clk);
      chk("forced thermal", {31'h0, low_side_gate_drive}, 32'h1);
      wb(`VSF_ADDR_CTRL, 1'b0, 32'h0);
      chk("ctrl read", rd, 32'h1 << `VSF_CTRL_THERM);
      wb(`VSF_ADDR_CTRL, 1'b1, 32'h0);
      repeat (8) @(negedge clk);
      chk("thermal latched", {31'h0, low_side_gate_drive}, 32'h1);
      chk("pwm off", {31'h0, pwm_enable}, 32'h0);
      $display("test faults done");
      test_done();
   end
endmodule // tb

/* verif/vsf_cpu_model.sv */
// Behavioural CPU and system logic on the code, select and mode pins.
// Assumes the bench sets wanted levels; impedance shows only through the device's pulls.
`timescale 1ns/1ps
module vsf_cpu_model #(
   parameter CODE_W = 5
) (
   input  wire logic              clk,
   input  wire logic              want_impedance_mode_select,
   input  wire logic              want_sus,
   input  wire logic [CODE_W-1:0] want_code,
   input  wire logic [CODE_W-1:0] want_hiz,
   input  wire logic [1:0]        want_scode,
   input  wire logic [1:0]        want_skip,
   input  wire logic [CODE_W-1:0] vid_pull_enable,
   input  wire logic [CODE_W-1:0] vid_pull_up,
   output logic                   impedance_mode_select,
   output logic                   suspend_select,
   output logic      [CODE_W-1:0] vid_code_inputs,
   output logic      [1:0]        suspend_code_inputs,
   output logic      [1:0]        skip_shutdown_control
);
   initial {impedance_mode_select, suspend_select, vid_code_inputs, suspend_code_inputs} = '0;
   initial skip_shutdown_control = 2'h2;
   always @(posedge clk)
   begin
      impedance_mode_select <= want_impedance_mode_select;
      suspend_select        <= want_sus;
      suspend_code_inputs   <= want_scode;
      skip_shutdown_control <= want_skip;
      // A high-impedance pin gives way to the pull, a strapped one does not
      vid_code_inputs <= (vid_pull_enable & want_hiz & vid_pull_up)
                       | (~(vid_pull_enable & want_hiz) & want_code);
   end
endmodule // vsf_cpu_model

/* verif/vsf_seq_checker.sv */
// Concurrent checks on the pin-side outputs of the VID slew and fault sequencer.
// Assumes the slew divider stays near its minimum and the CTRL disable bit is left clear.
`timescale 1ns/1ps
`include "vsf_regs.vh"
module vsf_seq_checker #(
   parameter CODE_W = 5
) (
   input wire logic              clk,
   input wire logic              reset_n,
   input wire logic [1:0]        skip_shutdown_control,
   input wire logic              overvoltage_disable_input,
   input wire logic              overvoltage_detect,
   input wire logic [CODE_W-1:0] vid_pull_enable,
   input wire logic [CODE_W-1:0] dac_code,
   input wire logic              power_good_output,
   input wire logic              low_side_gate_drive,
   input wire logic              pwm_enable,
   input wire logic              skip_enable
);
   logic [15:0] since;
   logic [15:0] pcnt;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Saturates so a start-up without any code change is not judged
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         since <= 16'hffff;
         pcnt  <= 16'h0000;
      end
      else
      begin
         if ($changed(dac_code))
            since <= 16'h0000;
         else if (since != 16'hffff)
            since <= since + 16'h0001;
         pcnt <= (|vid_pull_enable) ? pcnt + 16'h0001 : 16'h0000;
      end
   end
   dac_step_a: assert property (
      $changed(dac_code) |-> dac_code == $past(dac_code) + 6'h01 || dac_code + 6'h01 == $past(dac_code))
      else $error("dac moved more than one step");
   pgood_blank_a: assert property (
      $changed(dac_code) |-> $stable(power_good_output)) else $error("power good moved while stepping");
   pgood_tail_a: assert property (
      $rose(power_good_output) |-> since >= 16'h0102) else $error("power good back without tail period");
   dl_shutdown_a: assert property (
      (skip_shutdown_control == 2'h0)[*5] |-> low_side_gate_drive && !pwm_enable)
      else $error("shutdown without gate forced");
   ov_trip_a: assert property (
      (overvoltage_detect && !overvoltage_disable_input && skip_shutdown_control == 2'h2)[*4]
      |-> ##[0:3] (low_side_gate_drive && !pwm_enable)) else $error("overvoltage not tripped");
   fault_hold_a: assert property (
      (low_side_gate_drive && skip_shutdown_control inside {2'h1, 2'h2})[*8] |=> low_side_gate_drive)
      else $error("fault latch released without toggle");
   test_clear_a: assert property (
      (skip_shutdown_control == 2'h3)[*6] |-> !low_side_gate_drive && skip_enable)
      else $error("test mode kept fault");
   mode_open_a: assert property (
      (skip_shutdown_control == 2'h1)[*6] |-> !skip_enable) else $error("skip active in open mode");
   mode_auto_a: assert property (
      (skip_shutdown_control == 2'h2)[*6] ##0 pwm_enable |-> skip_enable) else $error("no auto skip");
   pull_time_a: assert property (
      $fell(|vid_pull_enable) |-> pcnt >= 16'h0186 && pcnt <= 16'h019a) else $error("pull time off");
endmodule // vsf_seq_checker
bind vsf_sequencer vsf_seq_checker #(.CODE_W(CODE_W)) u_chk (.clk, .reset_n, .skip_shutdown_control,
   .overvoltage_disable_input, .overvoltage_detect, .vid_pull_enable, .dac_code, .power_good_output,
   .low_side_gate_drive, .pwm_enable, .skip_enable);
